// file: rtl/gtb_pkg.sv
// Package: register map, field layout and reset values of the timer bank
package gtb_pkg;
  localparam int ADDR_W = 8;
  localparam int MAX_TMR = 6;
  localparam int MAX_CAP = 4;
  // Per-timer block: timer n sits at n * TMR_STRIDE
  localparam logic [7:0] TMR_STRIDE = 8'h10;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PSC_OFF = 8'h04;
  localparam logic [7:0] CMP_OFF = 8'h08;
  localparam logic [7:0] CNT_OFF = 8'h0C;
  // Capture values: capture n at CAP_BASE + 4 * n
  localparam logic [7:0] CAP_BASE = 8'h60;
  localparam logic [7:0] STAT_OFF = 8'h70;
  localparam logic [7:0] MASK_OFF = 8'h74;
  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int SEL_W = 2;
  // Status and mask layout
  localparam int STAT_TMR_LSB = 0;
  localparam int STAT_CAP_LSB = 8;
  // Reset values
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    MODE_AUTO = 1'h0,
    MODE_SINGLE = 1'h1
  } gtb_mode_t;
endpackage : gtb_pkg

// file: rtl/gtb_timer_if.sv
// Interface: control and status of one timer between bank and counter unit
`timescale 1ns/10ps
interface gtb_timer_if #(parameter int CW = 16, parameter int PW = 8);
  logic en;
  gtb_pkg::gtb_mode_t mode;
  logic [PW-1:0] psc;
  logic [CW-1:0] cmp;
  logic tick;
  logic cap_in;
  logic [CW-1:0] count;
  logic [CW-1:0] cap_val;
  logic hit;
  logic cap_evt;
  modport bank (output en, mode, psc, cmp, tick, cap_in, input count, cap_val, hit, cap_evt);
  modport unit (input en, mode, psc, cmp, tick, cap_in, output count, cap_val, hit, cap_evt);
endinterface : gtb_timer_if

// file: rtl/gtb_timer_unit.sv
// Module: one counter with prescaler, terminal detect and optional capture
`timescale 1ns/10ps
module gtb_timer_unit #(
  parameter int CW = 16,
  parameter int PW = 8,
  parameter bit HAS_CAP = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bank side
  gtb_timer_if.unit tif
);
  logic [PW-1:0] psc_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cap_q;
  logic en_d1_q;
  logic cap_prev_q;
  logic start;
  logic step;
  logic edge_seen;

  assign start = tif.en & ~en_d1_q;
  assign step = tif.en & ~start & tif.tick & (psc_q == tif.psc);
  assign tif.hit = step & (cnt_q == tif.cmp);
  assign edge_seen = tif.cap_in & ~cap_prev_q;
  assign tif.cap_evt = HAS_CAP & edge_seen;
  assign tif.count = cnt_q;
  assign tif.cap_val = cap_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_d1_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      en_d1_q <= tif.en;
      cap_prev_q <= tif.cap_in;
    end
  end

  // Prescaler restarts with each enable so the first period is whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_q <= '0;
    end else if (!tif.en || start) begin
      psc_q <= '0;
    end else if (tif.tick) begin
      psc_q <= (psc_q == tif.psc) ? '0 : psc_q + PW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= '0;
    end else if (tif.hit) begin
      cnt_q <= (tif.mode == gtb_pkg::MODE_SINGLE) ? cnt_q : '0;
    end else if (step) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= '0;
    end else if (tif.cap_evt) begin
      cap_q <= cnt_q;
    end
  end

  a_auto_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.hit && tif.mode == gtb_pkg::MODE_AUTO |=> cnt_q == '0)
    else $error("auto-reload counter did not restart at zero");
  a_single_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.hit && tif.mode == gtb_pkg::MODE_SINGLE |=> cnt_q == $past(cnt_q))
    else $error("single-shot counter moved after terminal count");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !tif.hit |=> cnt_q == $past(cnt_q) + CW'(1))
    else $error("counter did not advance by one on a tick");
  a_psc_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.en && tif.tick && psc_q == tif.psc && $stable(tif.psc) |=> psc_q == '0)
    else $error("prescaler did not wrap at programmed ratio");
  a_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !tif.en && !en_d1_q |=> $stable(cnt_q))
    else $error("disabled counter changed");
  a_cap_value: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.cap_evt |=> cap_q == $past(cnt_q))
    else $error("capture did not latch the count");
endmodule : gtb_timer_unit

// file: rtl/gtb_bank.sv
// Module: six-timer bank with AXI4-Lite registers, capture pins and interrupt
`timescale 1ns/10ps
module gtb_bank #(
  parameter int NUM_TMR = 6,
  parameter int NUM_CAP = 4,
  parameter int CNT_W = 16,
  parameter int PSC_W = 8,
  parameter int NUM_SRC = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [gtb_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [gtb_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Timer clock sources, one-cycle pulses from the clock generator
  input wire logic [NUM_SRC-1:0] src_tick,
  // Capture pins
  input wire logic [NUM_CAP-1:0] cap_in,
  // Interrupt
  output logic irq
);
  generate
    if (NUM_TMR < 1 || NUM_TMR > gtb_pkg::MAX_TMR || NUM_CAP > NUM_TMR || NUM_CAP > gtb_pkg::MAX_CAP
        || NUM_CAP < 1 || CNT_W < 1 || CNT_W > 16 || PSC_W < 1 || PSC_W > 8 || NUM_SRC != 3) begin : g_bad
      $error("gtb_bank: parameters outside what the register map serves");
    end
  endgenerate

  logic [NUM_TMR-1:0] en_q;
  gtb_pkg::gtb_mode_t mode_q [NUM_TMR];
  logic [gtb_pkg::SEL_W-1:0] sel_q [NUM_TMR];
  logic [PSC_W-1:0] psc_q [NUM_TMR];
  logic [CNT_W-1:0] cmp_q [NUM_TMR];
  logic [31:0] stat_q;
  logic [31:0] mask_q;
  logic [31:0] stat_set;
  logic [31:0] stat_clr;
  logic [NUM_TMR-1:0] hit;
  logic [NUM_CAP-1:0] stat_set_cap;
  logic irq_q;

  // AXI state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [gtb_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_val;
  logic [31:0] cnt_cap_val;
  logic cnt_cap_ok;

  gtb_timer_if #(.CW(CNT_W), .PW(PSC_W)) tif [NUM_TMR] ();

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      logic [31:0] ctrl_w;
      assign ctrl_w = merge({28'h0000000, sel_q[g], mode_q[g], en_q[g]}, wdata_q, wstrb_q);
      assign tif[g].en = en_q[g];
      assign tif[g].mode = mode_q[g];
      assign tif[g].psc = psc_q[g];
      assign tif[g].cmp = cmp_q[g];
      // Source 0 is the bus clock itself; higher codes pick generator pulses
      assign tif[g].tick = (sel_q[g] == '0) ? 1'b1 : src_tick[sel_q[g] - 2'h1];
      assign tif[g].cap_in = (g < NUM_CAP) ? cap_in[g % NUM_CAP] : 1'b0;
      assign hit[g] = tif[g].hit;

      gtb_timer_unit #(.CW(CNT_W), .PW(PSC_W), .HAS_CAP(g < NUM_CAP)) u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .tif(tif[g])
      );

      // Enable cleared by hardware on single-shot terminal wins over a write
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          en_q[g] <= 1'b0;
          mode_q[g] <= gtb_pkg::MODE_AUTO;
          sel_q[g] <= '0;
        end else begin
          if (wr_go && awaddr_q == 8'(g * gtb_pkg::TMR_STRIDE + gtb_pkg::CTRL_OFF)) begin
            en_q[g] <= ctrl_w[gtb_pkg::CTRL_EN_BIT];
            mode_q[g] <= gtb_pkg::gtb_mode_t'(ctrl_w[gtb_pkg::CTRL_MODE_BIT]);
            sel_q[g] <= ctrl_w[gtb_pkg::CTRL_SEL_LSB +: gtb_pkg::SEL_W];
          end
          if (hit[g] && mode_q[g] == gtb_pkg::MODE_SINGLE) begin
            en_q[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          psc_q[g] <= PSC_W'(gtb_pkg::PSC_RST);
          cmp_q[g] <= CNT_W'(gtb_pkg::CMP_RST);
        end else if (wr_go) begin
          if (awaddr_q == 8'(g * gtb_pkg::TMR_STRIDE + gtb_pkg::PSC_OFF)) begin
            psc_q[g] <= PSC_W'(merge(32'(psc_q[g]), wdata_q, wstrb_q));
          end
          if (awaddr_q == 8'(g * gtb_pkg::TMR_STRIDE + gtb_pkg::CMP_OFF)) begin
            cmp_q[g] <= CNT_W'(merge(32'(cmp_q[g]), wdata_q, wstrb_q));
          end
        end
      end

      a_single_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        hit[g] && mode_q[g] == gtb_pkg::MODE_SINGLE |=> !en_q[g] ##1 !en_q[g] || $past(wr_go))
        else $error("single-shot timer left enabled");
      a_hit_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        hit[g] |=> stat_q[gtb_pkg::STAT_TMR_LSB + g])
        else $error("terminal count did not set its status bit");
    end
  endgenerate

  always_comb begin
    stat_set = '0;
    stat_set[gtb_pkg::STAT_TMR_LSB +: NUM_TMR] = hit;
  end

  generate
    for (g = 0; g < NUM_CAP; g++) begin : g_capset
      assign stat_set_cap[g] = tif[g].cap_evt;
    end
  endgenerate

  assign stat_clr = (wr_go && awaddr_q == gtb_pkg::STAT_OFF) ? merge('0, wdata_q, wstrb_q) : '0;

  // A new event beats a same-cycle write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set
                | (32'(stat_set_cap) << gtb_pkg::STAT_CAP_LSB);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= gtb_pkg::MASK_RST;
    end else if (wr_go && awaddr_q == gtb_pkg::MASK_OFF) begin
      mask_q <= merge(mask_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Write channel: address and data taken in either order
  always_comb begin
    wr_ok = (awaddr_q == gtb_pkg::STAT_OFF) || (awaddr_q == gtb_pkg::MASK_OFF);
    for (int i = 0; i < NUM_TMR; i++) begin
      if (awaddr_q == 8'(i * gtb_pkg::TMR_STRIDE + gtb_pkg::CTRL_OFF)
          || awaddr_q == 8'(i * gtb_pkg::TMR_STRIDE + gtb_pkg::PSC_OFF)
          || awaddr_q == 8'(i * gtb_pkg::TMR_STRIDE + gtb_pkg::CMP_OFF)) begin
        wr_ok = 1'b1;
      end
    end
  end
  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= gtb_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      awready_q <= ~aw_have_q & ~(awvalid & awready_q) & ~bvalid_q;
      wready_q <= ~w_have_q & ~(wvalid & wready_q) & ~bvalid_q;
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {awaddr[gtb_pkg::ADDR_W-1:2], 2'h0};
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? gtb_pkg::RESP_OKAY : gtb_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read mux; count and capture registers are read-only views
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b0;
    if (araddr[7:2] == gtb_pkg::STAT_OFF[7:2]) begin
      rd_val = stat_q;
      rd_ok = 1'b1;
    end
    if (araddr[7:2] == gtb_pkg::MASK_OFF[7:2]) begin
      rd_val = mask_q;
      rd_ok = 1'b1;
    end
    for (int i = 0; i < NUM_TMR; i++) begin
      if (araddr[7:2] == 6'((i * gtb_pkg::TMR_STRIDE + gtb_pkg::CTRL_OFF) >> 2)) begin
        rd_val = 32'({sel_q[i], mode_q[i], en_q[i]});
        rd_ok = 1'b1;
      end
      if (araddr[7:2] == 6'((i * gtb_pkg::TMR_STRIDE + gtb_pkg::PSC_OFF) >> 2)) begin
        rd_val = 32'(psc_q[i]);
        rd_ok = 1'b1;
      end
      if (araddr[7:2] == 6'((i * gtb_pkg::TMR_STRIDE + gtb_pkg::CMP_OFF) >> 2)) begin
        rd_val = 32'(cmp_q[i]);
        rd_ok = 1'b1;
      end
    end
    rd_val = rd_val | cnt_cap_val;
    rd_ok = rd_ok | cnt_cap_ok;
  end

  logic [CNT_W-1:0] cnt_v [NUM_TMR];
  logic [CNT_W-1:0] cap_v [NUM_TMR];
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_view
      assign cnt_v[g] = tif[g].count;
      assign cap_v[g] = tif[g].cap_val;
    end
  endgenerate
  always_comb begin
    cnt_cap_val = '0;
    cnt_cap_ok = 1'b0;
    for (int i = 0; i < NUM_TMR; i++) begin
      if (araddr[7:2] == 6'((i * gtb_pkg::TMR_STRIDE + gtb_pkg::CNT_OFF) >> 2)) begin
        cnt_cap_val = 32'(cnt_v[i]);
        cnt_cap_ok = 1'b1;
      end
    end
    for (int i = 0; i < NUM_CAP; i++) begin
      if (araddr[7:2] == 6'((gtb_pkg::CAP_BASE + 4 * i) >> 2)) begin
        cnt_cap_val = 32'(cap_v[i]);
        cnt_cap_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= gtb_pkg::RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_q & ~(arvalid & arready_q);
      if (arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_ok ? rd_val : '0;
        rresp_q <= rd_ok ? gtb_pkg::RESP_OKAY : gtb_pkg::RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(stat_q & mask_q) |=> irq_q)
    else $error("unmasked status did not raise interrupt");
  a_no_cap_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_q[31:gtb_pkg::STAT_CAP_LSB + NUM_CAP] == '0)
    else $error("capture status set for a timer without capture");
endmodule : gtb_bank

// file: testbench/gtb_src_model.sv
// Partner model: clock generator tick sources and capture pin drivers
`timescale 1ns/10ps
module gtb_src_model #(
  parameter int DIV1 = 2,
  parameter int DIV2 = 3,
  parameter int DIV3 = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the bench
  input wire logic [3:0] cap_req,
  // Pins toward the bank
  output logic [2:0] src_tick,
  output logic [3:0] cap_in
);
  int cnt_q [3];
  int div [3];
  assign div[0] = DIV1;
  assign div[1] = DIV2;
  assign div[2] = DIV3;
  // Free-running dividers; ticks are single-cycle pulses
  always_ff @(posedge aclk) begin
    for (int k = 0; k < 3; k++) begin
      if (!aresetn || cnt_q[k] == div[k] - 1) begin
        cnt_q[k] <= 0;
      end else begin
        cnt_q[k] <= cnt_q[k] + 1;
      end
      src_tick[k] <= aresetn && (cnt_q[k] == div[k] - 1);
    end
  end
  // Capture pins are synchronous to aclk
  always_ff @(posedge aclk) begin
    cap_in <= aresetn ? cap_req : 4'h0;
  end
endmodule : gtb_src_model

// file: testbench/test_general_purpose_timer_bank.sv
// Testbench: register access, timing, modes, capture and interrupt of the timer bank
`timescale 1ns/10ps
module test_general_purpose_timer_bank;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w, c;
  logic [3:0] wstrb, cap_in, cap_req;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] src_tick;
  int fails, checked, cyc, n, m0, m1, t0;
  int divs [4] = '{1, 2, 3, 5};

  gtb_bank u_gtb_bank (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .src_tick(src_tick), .cap_in(cap_in), .irq(irq));
  gtb_src_model u_gtb_src_model (.aclk(aclk), .aresetn(aresetn), .cap_req(cap_req), .src_tick(src_tick),
    .cap_in(cap_in));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    int k;
    aw_done = 0;
    w_done = 0;
    k = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done) && k < 200) begin
      @(posedge aclk);
      k++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    if (k >= 200) fails++;
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (arready !== 1'b1 && k < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    if (k >= 200) fails++;
    d = rdata;
    r = rresp;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk("write response", {30'h0, gtb_pkg::RESP_OKAY}, {30'h0, rs});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    axi_rd(a, d, rs);
    chk("read response", {30'h0, gtb_pkg::RESP_OKAY}, {30'h0, rs});
  endtask : rd

  function automatic logic [7:0] ra(input int t, input logic [7:0] off);
    return 8'(t) * gtb_pkg::TMR_STRIDE + off;
  endfunction : ra

  // Programs one timer, enables it and counts cycles until irq
  task automatic run_tmr(input int t, input int src, input int psc, input int cmp, input bit one, output int cnt);
    int s;
    wr(gtb_pkg::STAT_OFF, 32'hFFFF_FFFF);
    wr(gtb_pkg::MASK_OFF, 32'h1 << t);
    wr(ra(t, gtb_pkg::PSC_OFF), 32'(psc));
    wr(ra(t, gtb_pkg::CMP_OFF), 32'(cmp));
    wr(ra(t, gtb_pkg::CTRL_OFF), 32'((src << gtb_pkg::CTRL_SEL_LSB) | (one << gtb_pkg::CTRL_MODE_BIT) | 1));
    s = cyc;
    while (irq !== 1'b1 && cyc - s < 4000) @(posedge aclk);
    cnt = cyc - s;
  endtask : run_tmr

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb, cap_req} = '0;
    bready = 1'b1;
    rready = 1'b1;
    cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and bus errors
    rd(ra(5, gtb_pkg::CMP_OFF), v);
    chk("compare reset", {16'h0, gtb_pkg::CMP_RST}, v);
    rd(ra(5, gtb_pkg::CTRL_OFF), v);
    chk("ctrl reset", 32'h0, v);
    rd(gtb_pkg::MASK_OFF, v);
    chk("mask reset", gtb_pkg::MASK_RST, v);
    axi_rd(8'h80, v, rs);
    chk("unmapped read resp", {30'h0, gtb_pkg::RESP_SLVERR}, {30'h0, rs});
    chk("unmapped read data", 32'h0, v);
    axi_wr(ra(0, gtb_pkg::CNT_OFF), 32'h5, rs);
    chk("count write refused", {30'h0, gtb_pkg::RESP_SLVERR}, {30'h0, rs});
    $display("Test reset and bus done");
    // All six timers in single-shot: same delay, halted, enable cleared
    for (int t = 0; t < 6; t++) begin
      run_tmr(t, 0, 0, 3, 1'b1, n);
      if (t == 0) m0 = n;
      chk("single shot delay", 32'(m0), 32'(n));
      rd(ra(t, gtb_pkg::CTRL_OFF), v);
      chk("enable cleared", 32'h2, v);
      rd(ra(t, gtb_pkg::CNT_OFF), v);
      rd(ra(t, gtb_pkg::CNT_OFF), w);
      chk("count halted", 32'h3, w);
      rd(gtb_pkg::STAT_OFF, v);
      chk("status bit", 32'h1 << t, v);
    end
    $display("Test six timers done");
    // Prescaler extremes: divide by 1 against divide by 256
    run_tmr(0, 0, 0, 2, 1'b1, m0);
    run_tmr(0, 0, 255, 2, 1'b1, m1);
    // Three steps to terminal, each 255 cycles longer
    chk_rng("prescale 256 extra", 765, 765, m1 - m0);
    // Each clock source against aclk
    run_tmr(1, 0, 0, 4, 1'b1, m0);
    for (int k = 1; k < 4; k++) begin
      run_tmr(1, k, 0, 4, 1'b1, n);
      chk_rng("source delay", 4 * divs[k] - 4 - divs[k], 4 * divs[k] - 4 + divs[k], n - m0);
    end
    $display("Test prescale and sources done");
    // Auto reload: period (cmp + 1) * (psc + 1)
    run_tmr(2, 0, 3, 9, 1'b0, n);
    t0 = cyc;
    wr(gtb_pkg::STAT_OFF, 32'h4);
    // Registered irq still high right after the clear
    repeat (2) @(posedge aclk);
    while (irq !== 1'b1 && cyc - t0 < 400) @(posedge aclk);
    chk_rng("auto period", 40, 40, cyc - t0);
    rd(ra(2, gtb_pkg::CNT_OFF), v);
    chk_rng("auto count range", 0, 9, int'(v));
    rd(ra(2, gtb_pkg::CTRL_OFF), v);
    chk("auto stays enabled", 32'h1, v);
    wr(ra(2, gtb_pkg::CTRL_OFF), 32'h0);
    $display("Test auto reload done");
    // Capture on timers 0..3, none on the other two
    for (int t = 0; t < 4; t++) begin
      wr(gtb_pkg::STAT_OFF, 32'hFFFF_FFFF);
      // Long period so the count cannot wrap between reads
      wr(ra(t, gtb_pkg::PSC_OFF), 32'h0);
      wr(ra(t, gtb_pkg::CMP_OFF), 32'hFFFF);
      wr(ra(t, gtb_pkg::CTRL_OFF), 32'h1);
      rd(ra(t, gtb_pkg::CNT_OFF), v);
      cap_req[t] <= 1'b1;
      @(posedge aclk);
      cap_req[t] <= 1'b0;
      rd(ra(t, gtb_pkg::CNT_OFF), w);
      rd(gtb_pkg::CAP_BASE + 8'(4 * t), c);
      chk_rng("capture value", int'(v), int'(w), int'(c));
      rd(gtb_pkg::STAT_OFF, v);
      chk("capture status", 32'h1 << (gtb_pkg::STAT_CAP_LSB + t), v & 32'hFF00);
      wr(ra(t, gtb_pkg::CTRL_OFF), 32'h0);
    end
    rd(gtb_pkg::STAT_OFF, v);
    chk("no capture on 4 and 5", 32'h0, v & 32'hF000);
    $display("Test capture done");
    // Masked event keeps irq low until unmasked, cleared by W1C
    wr(gtb_pkg::STAT_OFF, 32'hFFFF_FFFF);
    wr(gtb_pkg::MASK_OFF, 32'h0);
    wr(ra(4, gtb_pkg::CTRL_OFF), 32'h3);
    repeat (6) @(posedge aclk);
    rd(gtb_pkg::STAT_OFF, v);
    chk("masked status", 32'h10, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(gtb_pkg::MASK_OFF, 32'h10);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(gtb_pkg::STAT_OFF, 32'h10);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("Test interrupt done");
    print_verdict();
  end
endmodule : test_general_purpose_timer_bank
